//--- core/ebi_params.svh
// offsets, field positions, reset values and timing counts of the bus interface
// assumes a 40 MHz system clock; included by the bus interface module
`ifndef EBI_PARAMS_SVH
`define EBI_PARAMS_SVH
`define EBI_ADDR_LINES 11
`define EBI_ROW_MSB 17
`define EBI_ROW_LSB 9
`define EBI_A19_LINE 10
`define EBI_A0_LINE 9
`define EBI_MIN_WAITS 2'h2
`define EBI_POLL_PERIOD 3'h5
`define EBI_NMI_VECTOR 8'h02
`define EBI_RESET_ADDR 20'hffff0
`define EBI_NMI_FILTER 4
`define EBI_REF_PERIOD 16'h0100
`endif

//--- core/ebi_pkg.sv
// types shared by the external bus interface
// assumes nothing beyond a SystemVerilog compiler
package ebi_pkg;
	typedef enum logic [3:0] {S_IDLE, S_T1, S_T2, S_WAIT, S_T3, S_HOLD, S_ACK1, S_GAP, S_ACK2} ebi_state_t;
	// one bus request from the core
	typedef struct packed {
		logic wr;
		logic io;
		logic word;
		logic [19:0] addr;
		logic [15:0] wdata;
	} ebi_req_t;
	// pin group that floats during hold
	typedef struct packed {
		logic memory_request_strobe_n;
		logic memory_data_strobe_n;
		logic io_cycle_strobe_n;
		logic rw;
		logic ube_a18;
		logic refresh_n;
		logic [10:0] addr;
	} ebi_pins_t;
endpackage : ebi_pkg

//--- core/ebi_core.sv
// external bus interface: multiplexed address, strobes, waits, hold, interrupt pins, poll
// assumes core handshakes on req_valid_i/req_ready_o and signals instruction ends on instr_last_i
// Notes on behaviour
// - 20-bit address travels over 11 address lines in two phases; 9 of them are shared.
// - during memory request phase lines carry address bits 17 to 9.
// - during memory or I/O strobe lines carry bits 8 to 1 and 18.
// - bit 18 line carries bit 18 in request phase, byte enable later.
// - bits 19 and 0 sit on dedicated lines for the whole cycle.
// - system clock goes to the core and out on the clock pin.
// - external master requests hold; device grants with active-low acknowledge.
// - during grant address, low data, strobes, refresh and direction float.
// - maskable interrupt level is sampled only in an instruction's last cycle.
// - acknowledge goes low; vector arrives on low data byte with it.
// - I/O strobe low marks an I/O cycle with valid I/O address.
// - memory request low starts memory and I/O cycles with row address.
// - memory strobe low on writes only while write data is driven.
// - direction pin high for reads, low for writes.
// - non-maskable input must stay active several clocks; unmaskable, top priority.
// - accepted non-maskable interrupt taken after instruction as vector 2; wakes standby.
// - three peripheral inputs detected on selected edge; edge also ends halt.
// - poll continues at once on low, else rechecks every five clocks.
// - poll input reads low when its pin is not an input.
// - ready low is synchronised and adds at least two wait states.
// - reset overrides everything; execution restarts at address ffff0.
// - byte enable and bit 0 pick lanes; odd words take two cycles.
`include "ebi_params.svh"
module ebi_core import ebi_pkg::*; #(
	parameter int NMI_FILTER = `EBI_NMI_FILTER,
	parameter logic [15:0] REF_PERIOD = `EBI_REF_PERIOD
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input ebi_req_t req_i,
	output logic req_ready_o,
	output logic done_o,
	output logic [15:0] rdata_o,
	output ebi_pins_t pins_o,
	output logic pins_oe_o,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	output logic data_oe_o,
	input wire logic ready_i,
	input wire logic bus_hold_request_i,
	output logic bus_hold_grant_n_o,
	output logic vector_fetch_acknowledge_n_o,
	output logic system_clock_output_o,
	input wire logic instr_last_i,
	input wire logic int_i,
	input wire logic int_enable_i,
	input wire logic nmi_i,
	input wire logic nmi_rising_i,
	input wire logic [2:0] peripheral_edge_interrupt_i,
	input wire logic [2:0] edge_select_register_i,
	output logic [2:0] intp_req_o,
	output logic irq_take_o,
	output logic [7:0] irq_vector_o,
	output logic wake_o,
	input wire logic poll_start_i,
	input wire logic poll_i,
	input wire logic poll_is_input_i,
	output logic poll_done_o,
	output logic restart_o,
	output logic [19:0] restart_addr_o
);
	ebi_state_t st_r, st_nxt;
	ebi_req_t cur_r, cur_nxt;
	logic sec_r, sec_nxt, rdy_r, done_r, done_nxt;
	logic int_pend_r, int_pend_nxt; // read by the sequencer, so declared ahead of it
	logic [1:0] wcnt_r, wcnt_nxt;
	logic [15:0] rdata_r, rdata_nxt, dout_r, dout_nxt, lanes;
	logic [19:0] ea;
	logic ube_n, odd_word, strobe;

	// clock forwarded unchanged so peripherals see the core's own edges
	assign system_clock_output_o = clk_i;

	// effective address of this half; second half of an odd word is addr+1
	assign ea = cur_r.addr + {19'h0, sec_r};
	assign odd_word = cur_r.word & cur_r.addr[0];
	assign ube_n = sec_r ? 1'b1 : (cur_r.word ? 1'b0 : ~ea[0]);
	assign lanes = sec_r ? {cur_r.wdata[15:8], cur_r.wdata[15:8]}
		: (odd_word ? {cur_r.wdata[7:0], cur_r.wdata[7:0]} : cur_r.wdata);
	assign strobe = (st_r == S_T2) || (st_r == S_WAIT);
	assign req_ready_o = (st_r == S_IDLE) && !bus_hold_request_i && !int_pend_r;

	// bus cycle sequencer
	always_comb begin
		st_nxt = st_r;
		cur_nxt = cur_r;
		sec_nxt = sec_r;
		wcnt_nxt = wcnt_r;
		rdata_nxt = rdata_r;
		dout_nxt = dout_r;
		done_nxt = 1'b0;
		case (st_r)
			S_IDLE: begin
				if (bus_hold_request_i) begin
					st_nxt = S_HOLD;
				end else if (int_pend_r) begin
					st_nxt = S_ACK1;
				end else if (req_valid_i) begin
					cur_nxt = req_i;
					sec_nxt = 1'b0;
					st_nxt = S_T1;
				end
			end
			S_T1: begin
				dout_nxt = lanes;
				st_nxt = S_T2;
			end
			S_T2: begin
				if (!rdy_r) begin
					wcnt_nxt = `EBI_MIN_WAITS - 2'h1;
					st_nxt = S_WAIT;
				end else begin
					st_nxt = S_T3;
				end
			end
			S_WAIT: begin
				if (wcnt_r != 2'h0) begin
					wcnt_nxt = wcnt_r - 2'h1;
				end else if (rdy_r) begin
					st_nxt = S_T3;
				end
			end
			S_T3: begin
				// lane steering of the read data
				if (cur_r.word && !odd_word) begin
					rdata_nxt = data_i;
				end else if (odd_word && !sec_r) begin
					rdata_nxt[7:0] = data_i[15:8];
				end else if (sec_r) begin
					rdata_nxt[15:8] = data_i[7:0];
				end else begin
					rdata_nxt = {8'h00, ea[0] ? data_i[15:8] : data_i[7:0]};
				end
				if (odd_word && !sec_r) begin
					sec_nxt = 1'b1;
					st_nxt = S_T1;
				end else begin
					done_nxt = 1'b1;
					st_nxt = S_IDLE;
				end
			end
			S_HOLD: begin
				if (!bus_hold_request_i) begin
					st_nxt = S_IDLE;
				end
			end
			S_ACK1: st_nxt = S_GAP;
			S_GAP: st_nxt = S_ACK2;
			S_ACK2: st_nxt = S_IDLE;
			default: st_nxt = S_IDLE;
		endcase
	end

	// sequencer registers; ready passes one flop before use
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= S_IDLE;
			cur_r <= '0;
			sec_r <= 1'b0;
			wcnt_r <= 2'h0;
			rdata_r <= 16'h0000;
			dout_r <= 16'h0000;
			done_r <= 1'b0;
			rdy_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cur_r <= cur_nxt;
			sec_r <= sec_nxt;
			wcnt_r <= wcnt_nxt;
			rdata_r <= rdata_nxt;
			dout_r <= dout_nxt;
			done_r <= done_nxt;
			rdy_r <= ready_i;
		end
	end
	assign done_o = done_r;
	assign rdata_o = rdata_r;
	assign data_o = dout_r;
	assign data_oe_o = cur_r.wr && strobe;
	assign pins_oe_o = (st_r != S_HOLD);
	assign bus_hold_grant_n_o = (st_r != S_HOLD);
	assign vector_fetch_acknowledge_n_o = !((st_r == S_ACK1) || (st_r == S_ACK2));

	// refresh pulse generator; one low clock per period
	logic [15:0] ref_cnt_r, ref_cnt_nxt;
	always_comb begin
		ref_cnt_nxt = (ref_cnt_r == 16'h0000) ? REF_PERIOD - 16'h0001 : ref_cnt_r - 16'h0001;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_cnt_r <= 16'h0000;
		end else begin
			ref_cnt_r <= ref_cnt_nxt;
		end
	end

	// pin levels; dedicated lines follow the effective address all cycle
	always_comb begin
		pins_o = '0;
		pins_o.memory_request_strobe_n = 1'b1;
		pins_o.memory_data_strobe_n = 1'b1;
		pins_o.io_cycle_strobe_n = 1'b1;
		pins_o.rw = 1'b1;
		pins_o.refresh_n = (ref_cnt_r != 16'h0000);
		pins_o.addr[`EBI_A19_LINE] = ea[19];
		pins_o.addr[`EBI_A0_LINE] = ea[0];
		if (st_r == S_T1) begin
			pins_o.memory_request_strobe_n = 1'b0;
			pins_o.rw = !cur_r.wr;
			pins_o.addr[8:0] = ea[`EBI_ROW_MSB:`EBI_ROW_LSB];
			pins_o.ube_a18 = ea[18];
		end else if (strobe || st_r == S_T3) begin
			pins_o.memory_request_strobe_n = 1'b0;
			pins_o.rw = !cur_r.wr;
			pins_o.addr[8:0] = {ea[18], ea[8:1]};
			pins_o.ube_a18 = ube_n;
			pins_o.io_cycle_strobe_n = !(strobe && cur_r.io);
			pins_o.memory_data_strobe_n = !(strobe && !cur_r.io);
		end
	end

	// interrupt pins, vector capture and wake-up
	logic [3:0] nmi_cnt_r, nmi_cnt_nxt;
	logic nmi_lock_r, nmi_lock_nxt, nmi_pend_r, nmi_pend_nxt;
	logic take_r, take_nxt, wake_r, wake_nxt, nmi_act;
	logic [7:0] vec_r, vec_nxt;
	logic [2:0] intp_prev_r, intp_r, intp_nxt;
	genvar g;
	for (g = 0; g < 3; g++) begin : g_edge
		// selected edge per input; 1 selects rising
		assign intp_nxt[g] = edge_select_register_i[g]
			? (peripheral_edge_interrupt_i[g] & ~intp_prev_r[g])
			: (~peripheral_edge_interrupt_i[g] & intp_prev_r[g]);
	end
	assign nmi_act = nmi_rising_i ? nmi_i : !nmi_i;
	always_comb begin
		nmi_cnt_nxt = nmi_act ? nmi_cnt_r + 4'h1 : 4'h0;
		nmi_lock_nxt = nmi_act && nmi_lock_r;
		nmi_pend_nxt = nmi_pend_r;
		int_pend_nxt = int_pend_r;
		take_nxt = 1'b0;
		vec_nxt = vec_r;
		wake_nxt = |intp_nxt;
		if (nmi_act && nmi_lock_r) begin
			nmi_cnt_nxt = nmi_cnt_r;
		end
		// maskable level looked at only on the last instruction cycle
		if (int_i && int_enable_i && instr_last_i && !nmi_pend_r && !int_pend_r) begin
			int_pend_nxt = 1'b1;
		end
		if (st_r == S_ACK2) begin
			take_nxt = 1'b1;
			vec_nxt = data_i[7:0];
			int_pend_nxt = 1'b0;
		end else if (nmi_pend_r && instr_last_i) begin
			take_nxt = 1'b1;
			vec_nxt = `EBI_NMI_VECTOR;
			nmi_pend_nxt = 1'b0;
		end
		// filter: accept once per active period, only after NMI_FILTER clocks
		// placed after the take so a fresh acceptance wins over the clear
		if (nmi_act && !nmi_lock_r && nmi_cnt_r == 4'(NMI_FILTER - 1)) begin
			nmi_pend_nxt = 1'b1;
			nmi_lock_nxt = 1'b1;
			wake_nxt = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_cnt_r <= 4'h0;
			nmi_lock_r <= 1'b0;
			nmi_pend_r <= 1'b0;
			int_pend_r <= 1'b0;
			take_r <= 1'b0;
			vec_r <= 8'h00;
			wake_r <= 1'b0;
			intp_prev_r <= 3'h7;
			intp_r <= 3'h0;
		end else begin
			nmi_cnt_r <= nmi_cnt_nxt;
			nmi_lock_r <= nmi_lock_nxt;
			nmi_pend_r <= nmi_pend_nxt;
			int_pend_r <= int_pend_nxt;
			take_r <= take_nxt;
			vec_r <= vec_nxt;
			wake_r <= wake_nxt;
			intp_prev_r <= peripheral_edge_interrupt_i;
			intp_r <= intp_nxt;
		end
	end
	assign irq_take_o = take_r;
	assign irq_vector_o = vec_r;
	assign wake_o = wake_r;
	assign intp_req_o = intp_r;

	// poll wait and restart marker
	logic poll_busy_r, poll_busy_nxt, poll_done_r, poll_done_nxt, boot_r;
	logic [2:0] pcnt_r, pcnt_nxt;
	always_comb begin
		poll_busy_nxt = poll_busy_r;
		pcnt_nxt = pcnt_r;
		poll_done_nxt = 1'b0;
		if (poll_start_i && !poll_busy_r) begin
			if (!poll_i || !poll_is_input_i) begin
				poll_done_nxt = 1'b1;
			end else begin
				poll_busy_nxt = 1'b1;
				pcnt_nxt = `EBI_POLL_PERIOD - 3'h1;
			end
		end else if (poll_busy_r) begin
			if (pcnt_r != 3'h0) begin
				pcnt_nxt = pcnt_r - 3'h1;
			end else if (!poll_i || !poll_is_input_i) begin
				poll_done_nxt = 1'b1;
				poll_busy_nxt = 1'b0;
			end else begin
				pcnt_nxt = `EBI_POLL_PERIOD - 3'h1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			poll_busy_r <= 1'b0;
			pcnt_r <= 3'h0;
			poll_done_r <= 1'b0;
			boot_r <= 1'b1;
		end else begin
			poll_busy_r <= poll_busy_nxt;
			pcnt_r <= pcnt_nxt;
			poll_done_r <= poll_done_nxt;
			boot_r <= 1'b0;
		end
	end
	assign poll_done_o = poll_done_r;
	assign restart_o = boot_r;
	assign restart_addr_o = `EBI_RESET_ADDR;

	// checks
	a_row_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r == S_T1 |-> !pins_o.memory_request_strobe_n && pins_o.addr[8:0] == ea[17:9])
		else $error("row address wrong during request phase");
	a_col_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		!pins_o.memory_data_strobe_n |-> pins_o.addr[8:0] == {ea[18], ea[8:1]} && !pins_o.memory_request_strobe_n)
		else $error("column address wrong during strobe");
	a_float_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!bus_hold_grant_n_o |-> !pins_oe_o && !data_oe_o)
		else $error("bus driven while granted");
	a_hold_exit: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r == S_HOLD && !bus_hold_request_i |=> pins_oe_o && st_r == S_IDLE)
		else $error("hold not released");
	a_min_waits: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r == S_T2 && !rdy_r |=> (st_r == S_WAIT && !pins_o.memory_request_strobe_n) [*2])
		else $error("fewer than two wait states");
	a_write_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
		!pins_o.memory_data_strobe_n && !pins_o.rw |-> data_oe_o)
		else $error("write strobe without data");
	a_nmi_vector: assert property (@(posedge clk_i) disable iff (rst_i)
		nmi_pend_r && instr_last_i && st_r != S_ACK2 |=> irq_take_o && irq_vector_o == 8'h02)
		else $error("nmi not taken with vector 2");
	a_poll_period: assert property (@(posedge clk_i) disable iff (rst_i)
		poll_start_i && !poll_busy_r && poll_i && poll_is_input_i |=> !poll_done_o [*5])
		else $error("poll recheck too early");
	a_int_sample: assert property (@(posedge clk_i) disable iff (rst_i)
		!int_pend_r && !instr_last_i && st_r != S_ACK2 |=> !int_pend_r)
		else $error("interrupt latched outside last cycle");
endmodule : ebi_core

//--- tb/ebi_mem_model.sv
// partner model: memory, I/O device and interrupt controller behind the pins
// assumes floated pins are already pulled high by the bench
module ebi_mem_model import ebi_pkg::*; (
	input wire logic clk_i,
	input ebi_pins_t pins_i,
	input wire logic [15:0] dout_i,
	input wire logic doe_i,
	input wire logic ack_n_i,
	input wire logic slow_i,
	input wire logic [7:0] vec_i,
	output logic [15:0] data_o,
	output logic ready_o,
	output logic [19:0] adr_o,
	output logic [15:0] wd_o,
	output logic io_o,
	output logic ube_o,
	output logic rw_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] row_r;
	logic a18_r, a19_r;
	logic rd_r = 1'b0;
	logic [15:0] q_r, last_r = 16'h0000;
	logic stb;
	assign stb = !pins_i.memory_data_strobe_n || !pins_i.io_cycle_strobe_n;
	// slow device: ready low in the row phase forces waits
	assign ready_o = !(slow_i && !pins_i.memory_request_strobe_n && !stb);
	// vector with the acknowledge, read data for one cycle, else a moving pattern
	assign data_o = !ack_n_i ? {~last_r[15:8], vec_i} : rd_r ? q_r : ~last_r;
	// rebuild the address from both phases; bit 18 must show in both
	always @(posedge clk_i) begin
		if (!pins_i.memory_request_strobe_n && !stb) begin
			row_r <= pins_i.addr[8:0];
			a18_r <= pins_i.ube_a18;
			a19_r <= pins_i.addr[10];
		end
		if (stb) begin
			adr_o <= {a19_r, a18_r & pins_i.addr[8], row_r, pins_i.addr[7:0], pins_i.addr[9]};
			io_o <= !pins_i.io_cycle_strobe_n;
			rw_o <= pins_i.rw;
			ube_o <= pins_i.ube_a18;
			q_r <= {pins_i.addr[6:0], pins_i.addr[9], row_r[6:0], pins_i.addr[7]} ^ 16'h3c5a;
			if (!pins_i.rw && doe_i) wd_o <= dout_i;
		end
		rd_r <= stb && pins_i.rw;
		last_r <= data_o;
	end
endmodule // ebi_mem_model

//--- tb/ebi_core_tb.sv
// self-checking bench for the external bus interface core
// assumes ebi_mem_model as the far side of the pins
module ebi_core_tb import ebi_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0, rst_i = 1'b1, rv = 1'b0, slow = 1'b0, hrq = 1'b0, nr = 1'b1;
	logic il = 1'b0, ir = 1'b0, ie = 1'b0, nmi = 1'b0, ps = 1'b0, pl = 1'b0, pin = 1'b1;
	logic rdy, done, oe, doe, gnt_n, ack_n, clko, take, wake, pdone, restart, wk, tk, pd, mio, mrw, mrdy, mube;
	logic [2:0] pe = 3'h7, es = 3'h0, preq, pq;
	logic [7:0] vec;
	logic [15:0] rdata, dout, din, mdata, mwd;
	logic [19:0] raddr, madr;
	ebi_req_t rq = '0;
	ebi_pins_t pins, pw;
	int mismatches = 0, num_checks = 0, cyc_n = 0, acks, pd_at, rc;
	// pull-ups hold floated pins high; data bus follows its driver
	assign pw = oe ? pins : '1;
	assign din = doe ? dout : mdata;
	ebi_core #(.NMI_FILTER(2), .REF_PERIOD(16'h0100)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(rv),
		.req_i(rq), .req_ready_o(rdy), .done_o(done), .rdata_o(rdata), .pins_o(pins), .pins_oe_o(oe),
		.data_i(din), .data_o(dout), .data_oe_o(doe), .ready_i(mrdy), .bus_hold_request_i(hrq),
		.bus_hold_grant_n_o(gnt_n), .vector_fetch_acknowledge_n_o(ack_n), .system_clock_output_o(clko),
		.instr_last_i(il), .int_i(ir), .int_enable_i(ie), .nmi_i(nmi), .nmi_rising_i(nr),
		.peripheral_edge_interrupt_i(pe), .edge_select_register_i(es), .intp_req_o(preq), .irq_take_o(take),
		.irq_vector_o(vec), .wake_o(wake), .poll_start_i(ps), .poll_i(pl), .poll_is_input_i(pin),
		.poll_done_o(pdone), .restart_o(restart), .restart_addr_o(raddr));
	ebi_mem_model mem_u (.clk_i(clk_i), .pins_i(pw), .dout_i(dout), .doe_i(doe), .ack_n_i(ack_n),
		.slow_i(slow), .vec_i(8'h4b), .data_o(mdata), .ready_o(mrdy), .adr_o(madr), .wd_o(mwd),
		.io_o(mio), .ube_o(mube), .rw_o(mrw));
	initial forever #12.5 clk_i = ~clk_i;
	// cut a hang short far beyond the fewer than two hundred cycles needed
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 2000) begin
			mismatches++;
			$display("wrong value at %0t: run hung", $time);
			close_out;
		end
	end
	function automatic logic [15:0] rd(input logic [19:0] a);
		return {a[7:0], a[15:8]} ^ 16'h3c5a;
	endfunction
	task automatic chk(input logic [47:0] g, e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic clr;
		{wk, tk, pd, pq} = '0;
		acks = 0;
		rc = 0;
		pd_at = 0;
	endtask
	// sample settled outputs, then stop on the next edge so drives land on it
	task automatic run(input int c);
		repeat (c) begin
			#1;
			rc++;
			if (pdone === 1'b1 && pd !== 1'b1) pd_at = rc;
			pd |= pdone;
			wk |= wake;
			tk |= take;
			pq |= preq;
			acks += int'(ack_n === 1'b0);
			@(posedge clk_i);
		end
	endtask
	// request held until taken; n counts cycles up to the done pulse
	task automatic bus(input logic w, io, wd, input logic [19:0] a, input logic [15:0] d, input logic s, output int n);
		logic dn;
		rv <= 1'b1;
		rq <= '{w, io, wd, a, d};
		slow <= s;
		#1;
		while (rdy !== 1'b1) begin
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		rv <= 1'b0;
		n = 0;
		do begin
			#1;
			n++;
			dn = done;
			@(posedge clk_i);
		end while (dn !== 1'b1 && n < 40);
		// slow stays as set until the next call, so no double drive at one edge
	endtask
	task automatic t_hold;
		hrq <= 1'b1;
		run(3);
		#1;
		chk({gnt_n, oe, doe, rdy, &pw}, 5'h01);
		@(posedge clk_i);
		hrq <= 1'b0;
		run(2);
		#1;
		chk({gnt_n, oe}, 2'h3);
		@(posedge clk_i);
	endtask
	task automatic t_mem;
		int n;
		bus(1'b0, 1'b0, 1'b1, 20'hd5a36, 16'h0000, 1'b0, n);
		chk(n, 4);
		chk({madr, mrw, mio, mube}, {20'hd5a36, 3'h4});
		chk(rdata, rd(20'hd5a36));
		bus(1'b1, 1'b0, 1'b1, 20'h4c9e2, 16'ha55a, 1'b1, n);
		chk(n >= 6 && n < 12, 1'b1);
		chk({madr, mwd, mrw}, {20'h4c9e2, 16'ha55a, 1'b0});
	endtask
	task automatic t_io;
		int n;
		bus(1'b0, 1'b1, 1'b1, 20'h0813c, 16'h0000, 1'b0, n);
		chk({madr, mrw, mio}, {20'h0813c, 2'h3});
		chk(rdata, rd(20'h0813c));
	endtask
	task automatic t_odd;
		int n;
		logic [15:0] e, f;
		e = rd(20'h23457);
		f = rd(20'h23458);
		bus(1'b0, 1'b0, 1'b1, 20'h23457, 16'h0000, 1'b0, n);
		chk({n, rdata}, {32'd7, f[7:0], e[15:8]});
		chk(mube, 1'b1);
		// odd byte: one cycle, high lane, upper enable active
		bus(1'b0, 1'b0, 1'b0, 20'h23457, 16'h0000, 1'b0, n);
		chk({n, rdata}, {32'd4, 8'h00, e[15:8]});
		chk(mube, 1'b0);
	endtask
	task automatic t_int;
		clr;
		ir <= 1'b1;
		il <= 1'b1;
		run(1);
		il <= 1'b0;
		ie <= 1'b1;
		run(4);
		chk(acks, 0);
		il <= 1'b1;
		run(1);
		il <= 1'b0;
		repeat (8) begin
			run(1);
			if (acks > 0) ir <= 1'b0;
		end
		ie <= 1'b0;
		chk({acks, tk, vec}, {32'd2, 1'b1, 8'h4b});
	endtask
	task automatic t_nmi;
		clr;
		nmi <= 1'b1;
		run(1);
		nmi <= 1'b0;
		run(4);
		chk(wk, 1'b0);
		nmi <= 1'b1;
		run(4);
		chk({wk, tk}, 2'h2);
		il <= 1'b1;
		run(1);
		il <= 1'b0;
		run(3);
		chk({tk, vec}, {1'b1, 8'h02});
		// low-active polarity: the high level left on the pin is now idle
		nr <= 1'b0;
		run(2);
		clr;
		nmi <= 1'b0;
		run(4);
		chk({wk, tk}, 2'h2);
		il <= 1'b1;
		run(1);
		il <= 1'b0;
		run(2);
		chk({tk, vec}, {1'b1, 8'h02});
		nr <= 1'b1;
	endtask
	task automatic t_edge;
		for (int i = 0; i < 6; i++) begin
			es <= {3{i[0]}};
			pe <= {3{!i[0]}};
			run(3);
			clr;
			pe[i / 2] <= i[0];
			run(3);
			chk({pq, wk}, {3'h1 << (i / 2), 1'b1});
		end
	endtask
	task automatic t_poll;
		for (int i = 0; i < 3; i++) begin
			pl <= (i != 0);
			pin <= (i != 1);
			ps <= 1'b1;
			clr;
			run(1);
			ps <= 1'b0;
			run(11);
			if (i == 2) pl <= 1'b0;
			run(8);
			if (i < 2) chk(pd_at, 2);
			else chk(pd_at > 12 && pd_at < 19, 1'b1);
		end
	endtask
	initial begin
		clr;
		repeat (5) @(posedge clk_i);
		#1;
		chk({clko, restart, raddr}, {clk_i, 1'b1, 20'hffff0});
		@(posedge clk_i);
		rst_i <= 1'b0;
		run(2);
		chk(restart, 1'b0);
		t_hold;
		t_mem;
		t_io;
		t_odd;
		t_int;
		t_nmi;
		t_edge;
		t_poll;
		close_out;
	end
endmodule // ebi_core_tb
